/* File: hw/pp_port.sv */
// Parallel high-voltage programming port with its memories
`timescale 1ns/1ps
module pp_port
  import pp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Programming pins
  input  wire logic       i_hv_reset,
  input  wire logic       i_load_strobe,
  input  wire logic       i_strobe_action_1,
  input  wire logic       i_strobe_action_0,
  input  wire logic       i_byte_sel_lo,
  input  wire logic       i_byte_sel_ext,
  input  wire logic       i_page_load,
  input  wire logic       i_wr_n,
  input  wire logic       i_oe_n,
  // Data bus
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  // Status
  output logic            o_ready_busy_out,
  output logic            o_prog_mode,
  output logic      [7:0] o_osc_tune_reg
);
  // Pin synchronisers
  logic [PIN_W-1:0] pin_meta, pin_sync, pin_prev;
  logic [7:0]       dat_meta, dat_sync;
  // Port state
  state_t      state, next_state;
  logic [7:0]  cmd, next_cmd;
  logic [7:0]  addr_lo, next_addr_lo, addr_hi, next_addr_hi;
  logic [7:0]  data_lo, next_data_lo, data_hi, next_data_hi;
  logic [12:0] cnt, next_cnt;
  logic        dirty, next_dirty;
  logic [7:0]  fuse_lo, next_fuse_lo, fuse_hi, next_fuse_hi;
  logic [7:0]  fuse_ext, next_fuse_ext, lock, next_lock;
  logic [7:0]  next_o_data;
  // Memories and their write ports
  logic [15:0]      fl_mem [0:FL_LAST];
  logic [7:0]       ee_mem [0:EE_LAST];
  logic [15:0]      fl_buf [0:(1<<FL_PW)-1];
  logic [7:0]       ee_buf [0:(1<<EE_PW)-1];
  logic             fl_we, ee_we;
  logic [FL_AW-1:0] fl_wa;
  logic [EE_AW-1:0] ee_wa;
  logic [15:0]      fl_wd;
  logic [7:0]       ee_wd;
  // Decoded pins
  logic hv, ld, pgl, wrn, oen, bs1, bs2;
  logic [1:0] act;
  logic hv_rise, hv_fall, ld_rise, pgl_rise, wr_fall;
  logic [FL_AW-1:0] fl_addr;
  logic [EE_AW-1:0] ee_addr;
  logic [7:0] rd_data;

  assign {hv, ld, act, bs1, bs2, pgl, wrn, oen} = pin_sync;
  assign hv_rise  = hv & ~pin_prev[8];
  assign hv_fall  = ~hv & pin_prev[8];
  assign ld_rise  = ld & ~pin_prev[7];
  assign pgl_rise = pgl & ~pin_prev[2];
  assign wr_fall  = ~wrn & pin_prev[1];
  assign fl_addr  = {addr_hi[4:0], addr_lo};
  assign ee_addr  = {addr_hi[0], addr_lo};

  // Read-out selection
  always_comb begin
    rd_data = 8'h00;
    unique case (cmd)
      CMD_RD_FLASH: rd_data = bs1 ? fl_mem[fl_addr][15:8]
                                  : fl_mem[fl_addr][7:0];
      CMD_RD_EE:    rd_data = ee_mem[ee_addr];
      CMD_RD_FUSE: begin
        unique case ({bs2, bs1})
          2'b00: rd_data = fuse_lo;
          2'b11: rd_data = fuse_hi;
          2'b10: rd_data = fuse_ext;
          2'b01: rd_data = lock;
        endcase
      end
      CMD_RD_SIG: begin
        if (bs1) rd_data = (addr_lo == 8'h00) ? CAL_BYTE : 8'h00;
        else if (addr_lo == 8'h00) rd_data = SIG_B0;
        else if (addr_lo == 8'h01) rd_data = SIG_B1;
        else if (addr_lo == 8'h02) rd_data = SIG_B2;
        else rd_data = 8'h00;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // Next state of the port
  always_comb begin
    next_state = state;     next_cmd = cmd;
    next_addr_lo = addr_lo; next_addr_hi = addr_hi;
    next_data_lo = data_lo; next_data_hi = data_hi;
    next_cnt = cnt;         next_dirty = dirty;
    next_fuse_lo = fuse_lo; next_fuse_hi = fuse_hi;
    next_fuse_ext = fuse_ext;
    next_lock = lock;
    fl_we = 1'b0; fl_wa = fl_addr; fl_wd = ERASED_WORD;
    ee_we = 1'b0; ee_wa = ee_addr; ee_wd = ERASED_BYTE;
    // Holding registers load on the strobe edge
    if (state != ST_OFF && ld_rise) begin
      unique case (act)
        ACT_ADDR: if (bs1) next_addr_hi = dat_sync;
                  else next_addr_lo = dat_sync;
        ACT_DATA: if (bs1) next_data_hi = dat_sync;
                  else next_data_lo = dat_sync;
        ACT_CMD: if (state == ST_IDLE) begin
          next_cmd = dat_sync;
          if (dat_sync == CMD_NOP) next_dirty = 1'b0;
        end
        default: ;
      endcase
    end
    unique case (state)
      ST_OFF: if (hv_rise && {pgl, act, bs1} == 4'h0)
        next_state = ST_IDLE;
      ST_IDLE: if (wr_fall) begin
        next_cnt = 13'h0000;
        unique case (cmd)
          CMD_ERASE: next_state = ST_ERASE_FL;
          CMD_WR_FUSE: begin
            next_state = ST_FUSE_WR;
            if (bs1 && !bs2) next_fuse_hi = data_lo;
            else if (!bs1 && bs2) next_fuse_ext = data_lo;
            else next_fuse_lo = data_lo;
          end
          CMD_WR_LOCK: begin
            next_state = ST_FUSE_WR;
            next_lock = lock & data_lo;
          end
          CMD_WR_FLASH: if (dirty) next_state = ST_PAGE_FL;
          CMD_WR_EE:    if (dirty) next_state = ST_PAGE_EE;
          default: ;
        endcase
      end
      ST_ERASE_FL: begin
        fl_we = 1'b1;
        fl_wa = cnt;
        next_cnt = cnt + 13'h0001;
        if (cnt == FL_LAST[12:0]) begin
          next_lock = LOCK_RST;
          next_cnt = 13'h0000;
          next_state = fuse_hi[EEPROM_PRESERVE_FUSE_BIT] ? ST_ERASE_EE : ST_IDLE;
        end
      end
      ST_ERASE_EE: begin
        ee_we = 1'b1;
        ee_wa = cnt[EE_AW-1:0];
        next_cnt = cnt + 13'h0001;
        if (cnt == EE_LAST[12:0]) next_state = ST_IDLE;
      end
      ST_PAGE_FL: begin
        fl_we = 1'b1;
        fl_wa = {fl_addr[FL_AW-1:FL_PW], cnt[FL_PW-1:0]};
        fl_wd = fl_buf[cnt[FL_PW-1:0]];
        next_cnt = cnt + 13'h0001;
        if (cnt[FL_PW-1:0] == '1) begin
          next_state = ST_IDLE;
          next_dirty = 1'b0;
        end
      end
      ST_PAGE_EE: begin
        ee_we = 1'b1;
        ee_wa = {ee_addr[EE_AW-1:EE_PW], cnt[EE_PW-1:0]};
        ee_wd = ee_buf[cnt[EE_PW-1:0]];
        next_cnt = cnt + 13'h0001;
        if (cnt[EE_PW-1:0] == '1) begin
          next_state = ST_IDLE;
          next_dirty = 1'b0;
        end
      end
      ST_FUSE_WR: begin
        next_cnt = cnt + 13'h0001;
        if (cnt == FUSE_WR_LAST) next_state = ST_IDLE;
      end
    endcase
    // Page latch comes last so its set wins over a clear
    if (state != ST_OFF && pgl_rise) next_dirty = 1'b1;
    if (hv_fall) next_state = ST_OFF;
    next_o_data = rd_data;
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta <= PIN_IDLE; pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
      dat_meta <= 8'h00; dat_sync <= 8'h00;
      state <= ST_OFF; cmd <= CMD_NOP;
      addr_lo <= 8'h00; addr_hi <= 8'h00;
      data_lo <= 8'h00; data_hi <= 8'h00;
      cnt <= 13'h0000; dirty <= 1'b0;
      fuse_lo <= FUSE_LO_RST; fuse_hi <= FUSE_HI_RST;
      fuse_ext <= FUSE_EXT_RST; lock <= LOCK_RST;
      o_data <= 8'h00; o_data_oe <= 1'b0;
      o_ready_busy_out <= 1'b1; o_prog_mode <= 1'b0;
      o_osc_tune_reg <= CAL_BYTE;
    end else begin
      pin_meta <= {i_hv_reset, i_load_strobe, i_strobe_action_1,
                   i_strobe_action_0, i_byte_sel_lo, i_byte_sel_ext,
                   i_page_load, i_wr_n, i_oe_n};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      dat_meta <= i_data;
      dat_sync <= dat_meta;
      state <= next_state; cmd <= next_cmd;
      addr_lo <= next_addr_lo; addr_hi <= next_addr_hi;
      data_lo <= next_data_lo; data_hi <= next_data_hi;
      cnt <= next_cnt; dirty <= next_dirty;
      fuse_lo <= next_fuse_lo; fuse_hi <= next_fuse_hi;
      fuse_ext <= next_fuse_ext; lock <= next_lock;
      o_data <= next_o_data;
      o_data_oe <= (next_state != ST_OFF) && !oen;
      o_ready_busy_out <= (next_state == ST_IDLE) ||
                          (next_state == ST_OFF);
      o_prog_mode <= (next_state != ST_OFF);
    end
  end

  // Memory and page buffer writes
  always_ff @(posedge i_clk) begin
    if (fl_we) fl_mem[fl_wa] <= fl_wd;
    if (ee_we) ee_mem[ee_wa] <= ee_wd;
    if (state == ST_ERASE_FL) fl_buf[cnt[FL_PW-1:0]] <= ERASED_WORD;
    if (state == ST_ERASE_FL) ee_buf[cnt[EE_PW-1:0]] <= ERASED_BYTE;
    if (!i_rst && state != ST_OFF && pgl_rise) begin
      if (cmd == CMD_WR_EE) ee_buf[addr_lo[EE_PW-1:0]] <= data_lo;
      else fl_buf[addr_lo[FL_PW-1:0]] <= {data_hi, data_lo};
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_cmd_load;
    state == ST_IDLE && ld_rise && act == ACT_CMD;
  endsequence
  sequence s_page_fl_run;
    (state == ST_PAGE_FL || state == ST_OFF);
  endsequence
  sequence s_erase_go;
    state == ST_IDLE && cmd == CMD_ERASE && wr_fall && !hv_fall;
  endsequence

  property p_erase_busy;
    s_erase_go |=> state == ST_ERASE_FL && !o_ready_busy_out;
  endproperty
  a_erase_busy: assert property (p_erase_busy)
    else $error("erase did not pull ready low");

  property p_busy_low;
    (state != ST_IDLE && state != ST_OFF) |-> !o_ready_busy_out;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("ready high during operation");

  property p_oe_drive;
    o_data_oe |-> $past(!oen) && state != ST_OFF;
  endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("data bus driven without output enable");

  property p_cmd_load;
    s_cmd_load |=> cmd == $past(dat_sync);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("command byte not loaded");

  property p_nop_clear;
    s_cmd_load ##0 (dat_sync == CMD_NOP) && !pgl_rise |=> !dirty;
  endproperty
  a_nop_clear: assert property (p_nop_clear)
    else $error("no-operation left page state set");

  property p_exit;
    hv_fall |=> state == ST_OFF && !o_prog_mode;
  endproperty
  a_exit: assert property (p_exit)
    else $error("reset pin low did not leave mode");

  property p_page_fl;
    $rose(state == ST_PAGE_FL) |-> ##63 s_page_fl_run;
  endproperty
  a_page_fl: assert property (p_page_fl)
    else $error("flash page shorter than 64 words");

  property p_lock_clear;
    $rose(lock == LOCK_RST) |-> $past(state == ST_ERASE_FL);
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("lock bits cleared outside flash erase end");

  property p_ee_keep;
    state == ST_ERASE_EE |-> fuse_hi[EEPROM_PRESERVE_FUSE_BIT];
  endproperty
  a_ee_keep: assert property (p_ee_keep)
    else $error("EEPROM erased with preserve fuse programmed");

  property p_page_ee;
    $rose(state == ST_PAGE_EE) && !hv_fall
      |-> ##3 (state == ST_PAGE_EE || state == ST_OFF);
  endproperty
  a_page_ee: assert property (p_page_ee)
    else $error("EEPROM page shorter than 4 bytes");
endmodule : pp_port

/* File: hw/pp_pkg.sv */
// Constants and types for the parallel programming port
package pp_pkg;
  // Memory geometry (largest variant)
  localparam int FL_AW   = 13;
  localparam int FL_PW   = 6;
  localparam int EE_AW   = 9;
  localparam int EE_PW   = 2;
  localparam int FL_LAST = 8191;
  localparam int EE_LAST = 511;
  // Strobe action codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  // Command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;
  // Identity and calibration bytes, values arbitrary
  localparam logic [7:0] CAL_BYTE = 8'h80;
  localparam logic [7:0] SIG_B0   = 8'h5a;
  localparam logic [7:0] SIG_B1   = 8'h01;
  localparam logic [7:0] SIG_B2   = 8'h02;
  // Fuse and lock reset values, erased contents
  localparam logic [7:0]  FUSE_LO_RST  = 8'h62;
  localparam logic [7:0]  FUSE_HI_RST  = 8'hdf;
  localparam logic [7:0]  FUSE_EXT_RST = 8'hf9;
  localparam logic [7:0]  LOCK_RST     = 8'hff;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam int          EEPROM_PRESERVE_FUSE_BIT   = 3;
  // Last count of a fuse or lock write busy time, in cycles
  localparam logic [12:0] FUSE_WR_LAST = 13'h000f;
  // Pin bundle layout and idle level
  localparam int           PIN_W    = 9;
  localparam logic [8:0]   PIN_IDLE = 9'h003;
  // Port state
  typedef enum logic [6:0] {
    ST_OFF      = 7'h01,
    ST_IDLE     = 7'h02,
    ST_ERASE_FL = 7'h04,
    ST_ERASE_EE = 7'h08,
    ST_PAGE_FL  = 7'h10,
    ST_PAGE_EE  = 7'h20,
    ST_FUSE_WR  = 7'h40
  } state_t;
endpackage : pp_pkg

/* File: verif/prog_model.sv */
// Programmer model that drives the programming pins
`timescale 1ns/1ps
module prog_model (
  // Clock and device read-back
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dev,
  input  wire logic       i_dev_oe,
  // Programming pins
  output logic            o_hv,
  output logic            o_stb,
  output logic      [1:0] o_act,
  output logic            o_bs1,
  output logic            o_bs2,
  output logic            o_pl,
  output logic            o_wr_n,
  output logic            o_oe_n,
  output logic      [7:0] o_bus
);
  localparam int PW = 26;
  logic [7:0] drv;
  // Device owns the bus only while reading
  assign o_bus = i_dev_oe ? i_dev : drv;
  initial begin
    {o_hv, o_stb, o_act, o_bs1, o_bs2, o_pl} = '0;
    o_wr_n = 1'b1;
    o_oe_n = 1'b1;
    drv    = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // High voltage over an enable signature
  task automatic enter(input logic [3:0] sig, input logic settle);
    {o_pl, o_act, o_bs1} <= sig;
    tick(4);
    o_hv <= 1'b1;
    tick(1000);
    if (settle) tick(30000);
  endtask : enter
  task automatic leave();
    o_hv <= 1'b0;
    tick(8);
  endtask : leave
  // One byte on a load strobe pulse
  task automatic load(input logic [1:0] act, input logic bs,
                      input logic [7:0] d);
    o_act <= act;
    o_bs1 <= bs;
    drv   <= d;
    tick(4);
    o_stb <= 1'b1;
    tick(PW);
    o_stb <= 1'b0;
    tick(PW);
  endtask : load
  task automatic pload();
    o_bs1 <= 1'b1;
    tick(4);
    o_pl <= 1'b1;
    tick(PW);
    o_pl <= 1'b0;
    tick(PW);
  endtask : pload
  task automatic wr(input logic b1, input logic b2);
    o_bs1 <= b1;
    o_bs2 <= b2;
    tick(4);
    o_wr_n <= 1'b0;
    tick(PW);
    o_wr_n <= 1'b1;
    tick(4);
  endtask : wr
  // Released bus shows a changed value, not the last one
  task automatic rd(input logic b1, input logic b2, output logic [7:0] v,
                    output logic oe);
    o_bs1  <= b1;
    o_bs2  <= b2;
    drv    <= ~drv;
    o_oe_n <= 1'b0;
    tick(8);
    v  = o_bus;
    oe = i_dev_oe;
    o_oe_n <= 1'b1;
    tick(8);
  endtask : rd
endmodule : prog_model

/* File: verif/parallel_nvm_programming_port_tb.sv */
// Self-checking bench for the parallel programming port
`timescale 1ns/1ps
module parallel_nvm_programming_port_tb;
  import pp_pkg::*;
  logic        clk, rst, hv, stb, bs1, bs2, pl, wr_n, oe_n, doe, rdy, pm, o;
  logic [1:0]  act;
  logic [7:0]  bus, dout, tune, v, ahi, alo, ea, eh, lk;
  logic [7:0]  sig [3];
  logic [7:0]  eb [4];
  logic [7:0]  fz [4];
  logic [5:0]  wi [3];
  logic [15:0] fw [3];
  logic [31:0] seed;
  int          num_errors, check_count, cyc, busy_cnt;
  prog_model m (.i_clk(clk), .i_dev(dout), .i_dev_oe(doe), .o_hv(hv),
    .o_stb(stb), .o_act(act), .o_bs1(bs1), .o_bs2(bs2), .o_pl(pl),
    .o_wr_n(wr_n), .o_oe_n(oe_n), .o_bus(bus));
  pp_port dut (.i_clk(clk), .i_rst(rst), .i_hv_reset(hv),
    .i_load_strobe(stb), .i_strobe_action_1(act[1]),
    .i_strobe_action_0(act[0]), .i_byte_sel_lo(bs1), .i_byte_sel_ext(bs2),
    .i_page_load(pl), .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(bus),
    .o_data(dout), .o_data_oe(doe), .o_ready_busy_out(rdy),
    .o_prog_mode(pm), .o_osc_tune_reg(tune));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] rnd();
    seed = xs(seed);
    return seed[7:0];
  endfunction : rnd
  // Lock write only ever programs bits
  function automatic logic [7:0] lock_exp(input logic [7:0] d);
    return LOCK_RST & d;
  endfunction : lock_exp
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic rd_chk(input logic b1, input logic b2, input logic [7:0] e);
    m.rd(b1, b2, v, o);
    check(v, e);
    check(o, 1'b1);
  endtask : rd_chk
  // Write strobe, then wait for ready and count busy cycles
  task automatic do_wr(input logic b1, input logic b2, input int e);
    int n;
    busy_cnt = 0;
    m.wr(b1, b2);
    n = 0;
    while (rdy !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check(16'(busy_cnt), 16'(e));
  endtask : do_wr
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Busy counter and hang limit
  always @(posedge clk) begin
    cyc++;
    if (rdy === 1'b0) busy_cnt++;
    if (cyc == 90000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    {num_errors, check_count, cyc, busy_cnt} = '0;
    seed = 32'h0000_309f;
    sig = '{SIG_B0, SIG_B1, SIG_B2};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(tune, CAL_BYTE);
    check(rdy, 1'b1);
    m.enter(4'h1, 1'b0);
    check(pm, 1'b0);
    m.leave();
    m.enter(4'h0, 1'b1);
    check(pm, 1'b1);
    $display("entry test done");
    m.load(ACT_CMD, 1'b0, CMD_RD_SIG);
    m.load(ACT_ADDR, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      m.load(ACT_ADDR, 1'b0, 8'(i));
      rd_chk(1'b0, 1'b0, sig[i]);
    end
    m.load(ACT_ADDR, 1'b0, 8'h00);
    rd_chk(1'b1, 1'b0, CAL_BYTE);
    m.load(ACT_CMD, 1'b0, CMD_ERASE);
    do_wr(1'b0, 1'b0, FL_LAST + EE_LAST + 2);
    // Flash page with first, last and a random word
    ahi = rnd() & 8'h1f;
    alo = rnd() & 8'hc0;
    wi = '{6'h00, 6'h3f, 6'(rnd() % 60 + 2)};
    m.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    m.load(ACT_ADDR, 1'b1, ahi);
    for (int i = 0; i < 3; i++) begin
      fw[i] = {rnd(), rnd()};
      m.load(ACT_ADDR, 1'b0, alo | 8'(wi[i]));
      m.load(ACT_DATA, 1'b0, fw[i][7:0]);
      m.load(ACT_DATA, 1'b1, fw[i][15:8]);
      m.pload();
    end
    do_wr(1'b0, 1'b0, 64);
    m.pload();
    m.load(ACT_CMD, 1'b0, CMD_NOP);
    m.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    do_wr(1'b0, 1'b0, 0);
    m.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    for (int i = 0; i < 3; i++) begin
      m.load(ACT_ADDR, 1'b0, alo | 8'(wi[i]));
      rd_chk(1'b0, 1'b0, fw[i][7:0]);
      rd_chk(1'b1, 1'b0, fw[i][15:8]);
    end
    m.load(ACT_ADDR, 1'b0, alo | 8'(wi[2] ^ 6'h01));
    rd_chk(1'b0, 1'b0, ERASED_BYTE);
    m.load(ACT_ADDR, 1'b0, alo ^ 8'h40);
    rd_chk(1'b0, 1'b0, ERASED_BYTE);
    $display("flash test done");
    ea = rnd() & 8'hfc;
    eh = rnd() & 8'h01;
    m.load(ACT_CMD, 1'b0, CMD_WR_EE);
    m.load(ACT_ADDR, 1'b1, eh);
    for (int i = 0; i < 4; i++) begin
      eb[i] = rnd();
      m.load(ACT_ADDR, 1'b0, ea | 8'(i));
      m.load(ACT_DATA, 1'b0, eb[i]);
      m.pload();
    end
    do_wr(1'b0, 1'b0, 4);
    m.load(ACT_CMD, 1'b0, CMD_NOP);
    m.load(ACT_CMD, 1'b0, CMD_RD_EE);
    for (int i = 0; i < 4; i++) begin
      m.load(ACT_ADDR, 1'b0, ea | 8'(i));
      rd_chk(1'b0, 1'b0, eb[i]);
    end
    m.load(2'h3, 1'b0, ~ea);
    rd_chk(1'b0, 1'b0, eb[3]);
    $display("eeprom test done");
    // Fuse slots by {ext, lo} select; high fuse keeps EEPROM on erase
    lk = rnd() & 8'hfe;
    fz = '{rnd(), lock_exp(lk), rnd(), rnd()};
    fz[3][EEPROM_PRESERVE_FUSE_BIT] = 1'b0;
    m.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        m.load(ACT_DATA, 1'b0, fz[k]);
        do_wr(k == 3, k == 2, 16);
      end
    end
    m.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    m.load(ACT_DATA, 1'b0, lk);
    do_wr(1'b0, 1'b0, 16);
    m.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    for (int k = 0; k < 4; k++) begin
      rd_chk(k[0], k[1], fz[k]);
    end
    $display("fuse test done");
    m.load(ACT_CMD, 1'b0, CMD_ERASE);
    do_wr(1'b0, 1'b0, FL_LAST + 1);
    m.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd_chk(1'b1, 1'b0, LOCK_RST);
    rd_chk(1'b1, 1'b1, fz[3]);
    m.load(ACT_CMD, 1'b0, CMD_RD_EE);
    m.load(ACT_ADDR, 1'b0, ea);
    rd_chk(1'b0, 1'b0, eb[0]);
    m.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    m.load(ACT_ADDR, 1'b1, ahi);
    m.load(ACT_ADDR, 1'b0, alo);
    rd_chk(1'b0, 1'b0, ERASED_BYTE);
    m.leave();
    check(pm, 1'b0);
    $display("erase and exit test done");
    stop_test();
  end
endmodule : parallel_nvm_programming_port_tb
